// ---- hw/ddrrw_ctrl.sv ----
/*
  Controller end: local request handshake, four-entry command queue,
  row/column/bank mapping, precharge/activate sequencing, write data
  buffering and read return with optional ECC delay.
  Assumes the PHY end returns read data in command order.
*/
`default_nettype none
// How it works
// (R1) Half rate: size one, one four-beat burst
// (R2) Accepted when ready high; next next cycle
// (R3) Requester holds request while ready low
// (R4) Queue four requests, ready while room; a memory-mapped write also needs write buffer room and no word owed
// (R5) Ready low when queue full
// (R6) Each queued request becomes memory command
// (R7) Read strobe high for expected data cycles
// (R8) PHY issues reads and captures data
// (R9) PHY resyncs data, flags valid
// (R10) Local read valid marks valid read data
// (R11) Read delay zero, or one/three with ECC
// (R12) Split address; column shifted left two
// (R13) Row miss: precharge, activate, then access
// (R14) Native: request write data after accept
// (R15) Requester drives data cycle after request
// (R16) Write valid flags data and masks
// (R17) PHY sends write data and strobe
// (R18) Full rate: sizes one, two, in order
// (R19) Byte enables inverted into data mask
// (R20) Read data returned in request order
module ddrrw_ctrl (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              resetn,
  // Mode straps
  input  wire logic                              half_rate,
  input  wire logic                              native_mode,
  input  wire logic [1:0]                        ecc_lat,
  // Local request
  input  wire logic                              read_req,
  input  wire logic                              write_req,
  input  wire logic [ddrrw_pkg::SIZE_W-1:0]      size,
  input  wire logic [ddrrw_pkg::ADDR_W-1:0]      addr,
  output logic                                   ready,
  output logic                                   size_error,
  // Local write data
  output logic                                   wdata_req,
  input  wire logic [ddrrw_pkg::DATA_W-1:0]      wdata,
  input  wire logic [ddrrw_pkg::BE_W-1:0]        user_byte_enables,
  // Local read data
  output logic [ddrrw_pkg::DATA_W-1:0]           rdata,
  output logic                                   rdata_valid,
  // PHY link
  ddrrw_phy_if.ctrl                              link
);
  localparam int WFW = ddrrw_pkg::DATA_W + ddrrw_pkg::BE_W;

  ddrrw_pkg::ddrrw_req_t          q_r [ddrrw_pkg::QDEPTH];
  logic [ddrrw_pkg::QPTR_W-1:0]   qwp_r;
  logic [ddrrw_pkg::QPTR_W-1:0]   qrp_r;
  logic [ddrrw_pkg::QCNT_W-1:0]   qcnt_r;
  ddrrw_pkg::ddrrw_req_t          head;
  logic                           q_full;
  logic                           q_empty;
  logic                           size_ok;
  logic                           accept;
  logic                           push;
  logic                           pop;
  ddrrw_pkg::ddrrw_state_t        st_r;
  ddrrw_pkg::ddrrw_state_t        st_nxt;
  ddrrw_pkg::ddrrw_cmd_t          cmd_nxt;
  logic                           cur_wr_r;
  logic [ddrrw_pkg::SIZE_W-1:0]   beat_r;
  logic [ddrrw_pkg::NBANK-1:0]    open_r;
  logic [ddrrw_pkg::ROW_W-1:0]    row_r [ddrrw_pkg::NBANK];
  logic [ddrrw_pkg::BANK_W-1:0]   hbank;
  logic [ddrrw_pkg::ROW_W-1:0]    hrow;
  logic                           wr_data_ok;
  logic [ddrrw_pkg::WF_LVL_W-1:0] owed_r;
  logic [ddrrw_pkg::WF_LVL_W-1:0] owed_add;
  logic                           req_d_r;
  logic                           wf_in_ready;
  logic                           wf_out_valid;
  logic [WFW-1:0]                 wf_out;
  logic [ddrrw_pkg::WF_LVL_W-1:0] wf_level;
  logic                           mm_push;
  logic [ddrrw_pkg::ECC_STAGES:0] pv_r;
  logic [ddrrw_pkg::DATA_W-1:0]   pd_r [ddrrw_pkg::ECC_STAGES+1];

  // Address field extraction, used for queue head and bookkeeping
  function automatic logic [ddrrw_pkg::ROW_W-1:0] f_row(input logic [ddrrw_pkg::ADDR_W-1:0] a);
    f_row = a[ddrrw_pkg::ROW_LSB +: ddrrw_pkg::ROW_W];
  endfunction : f_row

  function automatic logic [ddrrw_pkg::BANK_W-1:0] f_bank(input logic [ddrrw_pkg::ADDR_W-1:0] a);
    f_bank = a[ddrrw_pkg::BANK_LSB +: ddrrw_pkg::BANK_W];
  endfunction : f_bank

  // ----------------------------------------------------------------
  // Request handshake and command queue
  // ----------------------------------------------------------------
  assign q_full  = (qcnt_r == ddrrw_pkg::QCNT_W'(ddrrw_pkg::QDEPTH));
  assign q_empty = (qcnt_r == '0);
  assign head    = q_r[qrp_r];
  assign size_ok = half_rate ? (size == ddrrw_pkg::SIZE_ONE) // (R1)
                             : (size == ddrrw_pkg::SIZE_ONE || size == ddrrw_pkg::SIZE_TWO); // (R18)
  // Memory-mapped writes carry their first word, so room must exist now
  assign ready   = !q_full && // (R4) (R5)
                   !(write_req && !read_req && !native_mode &&
                     (!wf_in_ready || owed_r != '0 || req_d_r));
  assign accept  = ready && (read_req || write_req); // (R2)
  assign push    = accept && size_ok;
  assign mm_push = push && write_req && !read_req && !native_mode;
  assign size_error = accept && !size_ok;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      q_r[qwp_r] <= '{is_wr: write_req && !read_req, size: size, addr: addr};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      qwp_r  <= '0;
      qrp_r  <= '0;
      qcnt_r <= '0;
    end else begin
      qwp_r  <= qwp_r + ddrrw_pkg::QPTR_W'(push);
      qrp_r  <= qrp_r + ddrrw_pkg::QPTR_W'(pop);
      qcnt_r <= qcnt_r + ddrrw_pkg::QCNT_W'(push) - ddrrw_pkg::QCNT_W'(pop); // (R4)
    end
  end

  // ----------------------------------------------------------------
  // Write data request and buffer
  // ----------------------------------------------------------------
  assign owed_add  = !(push && write_req && !read_req) ? '0 :
                     native_mode ? ddrrw_pkg::WF_LVL_W'(size) : ddrrw_pkg::WF_LVL_W'(size - 1'b1);
  // Room is reserved for the word already asked for last cycle
  assign wdata_req = (owed_r != '0) &&
                     ((wf_level + ddrrw_pkg::WF_LVL_W'(req_d_r)) < ddrrw_pkg::WF_LVL_W'(ddrrw_pkg::WF_DEPTH)); // (R14)

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      owed_r  <= '0;
      req_d_r <= 1'b0;
    end else begin
      owed_r  <= owed_r + owed_add - ddrrw_pkg::WF_LVL_W'(wdata_req);
      req_d_r <= wdata_req; // (R15)
    end
  end

  ddrrw_fifo #(.W(WFW), .DEPTH(ddrrw_pkg::WF_DEPTH)) u_wfifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (req_d_r || mm_push), // (R15)
    .in_ready  (wf_in_ready),
    .in_data   ({wdata, user_byte_enables}),
    .out_valid (wf_out_valid),
    .out_ready (link.wdata_valid),
    .out_data  (wf_out),
    .level     (wf_level)
  );

  assign link.wdata_valid = (st_r == ddrrw_pkg::ST_DATA) && cur_wr_r && wf_out_valid; // (R16)
  assign link.wdata       = wf_out[WFW-1 -: ddrrw_pkg::DATA_W];
  assign link.wdata_mask  = ~wf_out[ddrrw_pkg::BE_W-1:0]; // (R19)
  assign link.doing_rd    = (st_r == ddrrw_pkg::ST_DATA) && !cur_wr_r; // (R7)

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  assign hbank      = f_bank(head.addr);
  assign hrow       = f_row(head.addr);
  assign wr_data_ok = !head.is_wr || (wf_level >= ddrrw_pkg::WF_LVL_W'(head.size));
  assign pop        = (st_r == ddrrw_pkg::ST_CMD) && wr_data_ok;

  always_comb begin
    st_nxt  = st_r;
    cmd_nxt = ddrrw_pkg::CMD_NOP;
    case (st_r)
      ddrrw_pkg::ST_IDLE: begin
        if (!q_empty) begin
          if (!open_r[hbank]) begin
            st_nxt = ddrrw_pkg::ST_ACT;
          end else if (row_r[hbank] != hrow) begin
            st_nxt = ddrrw_pkg::ST_PCH; // (R13)
          end else begin
            st_nxt = ddrrw_pkg::ST_CMD;
          end
        end
      end
      ddrrw_pkg::ST_PCH: begin
        cmd_nxt = ddrrw_pkg::CMD_PCH; // (R13)
        st_nxt  = ddrrw_pkg::ST_ACT;
      end
      ddrrw_pkg::ST_ACT: begin
        cmd_nxt = ddrrw_pkg::CMD_ACT; // (R13)
        st_nxt  = ddrrw_pkg::ST_CMD;
      end
      ddrrw_pkg::ST_CMD: begin
        if (wr_data_ok) begin
          cmd_nxt = head.is_wr ? ddrrw_pkg::CMD_WR : ddrrw_pkg::CMD_RD; // (R6)
          st_nxt  = ddrrw_pkg::ST_DATA;
        end
      end
      ddrrw_pkg::ST_DATA: begin
        if (beat_r == ddrrw_pkg::SIZE_ONE) begin
          st_nxt = ddrrw_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = ddrrw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r      <= ddrrw_pkg::ST_IDLE;
      link.cmd  <= ddrrw_pkg::CMD_NOP;
      link.row  <= '0;
      link.col  <= '0;
      link.bank <= '0;
    end else begin
      st_r      <= st_nxt;
      link.cmd  <= cmd_nxt; // (R6)
      link.row  <= hrow;
      link.col  <= {head.addr[ddrrw_pkg::COL_LSB +: ddrrw_pkg::COL_W], {ddrrw_pkg::COL_SHIFT{1'b0}}}; // (R12)
      link.bank <= hbank;
    end
  end

  // One data cycle per local word; strobes end with the last word
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cur_wr_r <= 1'b0;
      beat_r   <= '0;
    end else if (pop) begin
      cur_wr_r <= head.is_wr;
      beat_r   <= head.size; // (R7)
    end else if (st_r == ddrrw_pkg::ST_DATA) begin
      beat_r   <= beat_r - 1'b1;
    end
  end

  generate
    for (genvar b = 0; b < ddrrw_pkg::NBANK; b++) begin : g_bank
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          open_r[b] <= 1'b0;
          row_r[b]  <= '0;
        end else if (hbank == ddrrw_pkg::BANK_W'(b)) begin
          if (st_r == ddrrw_pkg::ST_PCH) begin
            open_r[b] <= 1'b0; // (R13)
          end else if (st_r == ddrrw_pkg::ST_ACT) begin
            open_r[b] <= 1'b1;
            row_r[b]  <= hrow;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read return with optional ECC delay, order kept by a plain pipe
  // ----------------------------------------------------------------
  assign pv_r[0] = link.rdata_valid;
  assign pd_r[0] = link.rdata;

  generate
    for (genvar s = 1; s <= ddrrw_pkg::ECC_STAGES; s++) begin : g_ecc
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          pv_r[s] <= 1'b0;
          pd_r[s] <= '0;
        end else begin
          pv_r[s] <= pv_r[s-1]; // (R20)
          pd_r[s] <= pd_r[s-1];
        end
      end
    end
  endgenerate

  always_comb begin
    case (ecc_lat)
      ddrrw_pkg::ECC_ONE: begin
        rdata_valid = pv_r[1]; // (R11)
        rdata       = pd_r[1];
      end
      ddrrw_pkg::ECC_THREE: begin
        rdata_valid = pv_r[3]; // (R11)
        rdata       = pd_r[3];
      end
      default: begin
        rdata_valid = pv_r[0]; // (R10) (R11)
        rdata       = pd_r[0];
      end
    endcase
  end
endmodule : ddrrw_ctrl
`default_nettype wire

// ---- hw/ddrrw_pkg.sv ----
/*
  Shared constants and types of the local read/write path of the DDR
  controller and of its PHY-side partner.
  Assumes one controller clock domain and one local word per data beat.
*/
`default_nettype none
package ddrrw_pkg;
  // ----------------------------------------------------------------
  // Widths and address layout
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 24;
  localparam int DATA_W     = 32;
  localparam int BE_W       = 4;
  localparam int COL_W      = 8;
  localparam int ROW_W      = 14;
  localparam int BANK_W     = 2;
  localparam int NBANK      = 4;
  localparam int COL_LSB    = 0;
  localparam int ROW_LSB    = 8;
  localparam int BANK_LSB   = 22;
  localparam int COL_SHIFT  = 2;
  localparam int MCOL_W     = COL_W + COL_SHIFT;
  localparam int SIZE_W     = 2;
  // ----------------------------------------------------------------
  // Depths and latencies
  // ----------------------------------------------------------------
  localparam int QDEPTH     = 4;
  localparam int QPTR_W     = 2;
  localparam int QCNT_W     = 3;
  localparam int WF_DEPTH   = 8;
  localparam int WF_LVL_W   = 4;
  localparam int ECC_STAGES = 3;
  localparam int PHY_RD_LAT = 2;
  localparam logic [SIZE_W-1:0] SIZE_ONE  = 2'h1;
  localparam logic [SIZE_W-1:0] SIZE_TWO  = 2'h2;
  localparam logic [1:0]        ECC_NONE  = 2'h0;
  localparam logic [1:0]        ECC_ONE   = 2'h1;
  localparam logic [1:0]        ECC_THREE = 2'h3;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0, CMD_ACT = 3'h1, CMD_RD = 3'h2, CMD_WR = 3'h3, CMD_PCH = 3'h4
  } ddrrw_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_PCH = 3'h1, ST_ACT = 3'h3, ST_CMD = 3'h2, ST_DATA = 3'h6
  } ddrrw_state_t;
  typedef struct packed {
    logic              is_wr;
    logic [SIZE_W-1:0] size;
    logic [ADDR_W-1:0] addr;
  } ddrrw_req_t;
endpackage : ddrrw_pkg
`default_nettype wire

// ---- hw/ddrrw_phy_if.sv ----
/*
  Link between the controller end and the PHY end.
  Assumes both ends run on the same controller clock.
*/
`default_nettype none
interface ddrrw_phy_if;
  ddrrw_pkg::ddrrw_cmd_t              cmd;
  logic [ddrrw_pkg::ROW_W-1:0]        row;
  logic [ddrrw_pkg::MCOL_W-1:0]       col;
  logic [ddrrw_pkg::BANK_W-1:0]       bank;
  logic                               doing_rd;
  logic                               wdata_valid;
  logic [ddrrw_pkg::DATA_W-1:0]       wdata;
  logic [ddrrw_pkg::BE_W-1:0]         wdata_mask;
  logic [ddrrw_pkg::DATA_W-1:0]       rdata;
  logic                               rdata_valid;
  modport ctrl (output cmd, row, col, bank, doing_rd, wdata_valid, wdata, wdata_mask,
                input  rdata, rdata_valid);
  modport phy  (input  cmd, row, col, bank, doing_rd, wdata_valid, wdata, wdata_mask,
                output rdata, rdata_valid);
endinterface : ddrrw_phy_if
`default_nettype wire

// ---- hw/ddrrw_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides and a fill level.
  Assumes DEPTH is a power of two.
*/
`default_nettype none
module ddrrw_fifo #(
  parameter int W     = 36,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  // Fill side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  // Drain side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  // Status
  output logic [$clog2(DEPTH):0]          level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;

  assign level     = wp_r - rp_r;
  assign in_ready  = (level != DEPTH[AW:0]);
  assign out_valid = (wp_r != rp_r);
  assign out_data  = mem[rp_r[AW-1:0]];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wp_r <= '0;
    end else if (in_valid && in_ready) begin
      wp_r <= wp_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (in_valid && in_ready) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rp_r <= '0;
    end else if (out_valid && out_ready) begin
      rp_r <= rp_r + 1'b1;
    end
  end
endmodule : ddrrw_fifo
`default_nettype wire

// ---- hw/ddrrw_phy.sv ----
/*
  PHY end: drives memory command pins, sends write data with strobe,
  captures read data and hands it back after a resync stage.
  Assumes memory returns read data PHY_RD_LAT cycles after the command.
*/
`default_nettype none
module ddrrw_phy (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              resetn,
  // Controller link
  ddrrw_phy_if.phy                               link,
  // Memory pins
  output ddrrw_pkg::ddrrw_cmd_t                  mem_cmd,
  output logic [ddrrw_pkg::ROW_W-1:0]            mem_row_addr,
  output logic [ddrrw_pkg::MCOL_W-1:0]           mem_col_addr,
  output logic [ddrrw_pkg::BANK_W-1:0]           mem_bank_addr,
  output logic [ddrrw_pkg::DATA_W-1:0]           mem_dq_o,
  input  wire logic [ddrrw_pkg::DATA_W-1:0]      mem_dq_i,
  output logic                                   mem_dq_oe_n,
  output logic [ddrrw_pkg::BE_W-1:0]             memory_data_mask,
  output logic                                   mem_dqs_o,
  output logic                                   mem_dqs_oe_n
);
  logic [ddrrw_pkg::PHY_RD_LAT-1:0] cap_en_r;
  logic                             cap_v_r;
  logic [ddrrw_pkg::DATA_W-1:0]     cap_d_r;
  logic                             rs_v_r;
  logic [ddrrw_pkg::DATA_W-1:0]     rs_d_r;

  // ----------------------------------------------------------------
  // Command and write data to memory
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mem_cmd       <= ddrrw_pkg::CMD_NOP;
      mem_row_addr  <= '0;
      mem_col_addr  <= '0;
      mem_bank_addr <= '0;
    end else begin
      mem_cmd       <= link.cmd; // (R8) (R17)
      mem_row_addr  <= link.row;
      mem_col_addr  <= link.col;
      mem_bank_addr <= link.bank;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mem_dq_o         <= '0;
      memory_data_mask <= '1;
      mem_dq_oe_n      <= 1'b1;
      mem_dqs_o        <= 1'b0;
      mem_dqs_oe_n     <= 1'b1;
    end else begin
      mem_dq_o         <= link.wdata; // (R17)
      memory_data_mask <= link.wdata_valid ? link.wdata_mask : '1;
      mem_dq_oe_n      <= !link.wdata_valid;
      mem_dqs_oe_n     <= !link.wdata_valid;
      mem_dqs_o        <= link.wdata_valid && !mem_dqs_o; // (R17)
    end
  end

  // ----------------------------------------------------------------
  // Read capture, window taken from the controller's read strobe
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < ddrrw_pkg::PHY_RD_LAT; i++) begin : g_cap
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          cap_en_r[i] <= 1'b0;
        end else begin
          cap_en_r[i] <= (i == 0) ? link.doing_rd : cap_en_r[(i == 0) ? 0 : i-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cap_v_r <= 1'b0;
      cap_d_r <= '0;
      rs_v_r  <= 1'b0;
      rs_d_r  <= '0;
    end else begin
      cap_v_r <= cap_en_r[ddrrw_pkg::PHY_RD_LAT-1]; // (R8)
      cap_d_r <= mem_dq_i;
      rs_v_r  <= cap_v_r; // (R9)
      rs_d_r  <= cap_d_r;
    end
  end

  assign link.rdata       = rs_d_r;
  assign link.rdata_valid = rs_v_r; // (R9)
endmodule : ddrrw_phy
`default_nettype wire

// ---- tb/ddrrw_chk.sv ----
/* Assertions on the controller-to-PHY link.
   Assumes one clock; tb instantiates it beside the link. */
`default_nettype none
module ddrrw_chk (
  // Clock and reset
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  // Link
  input wire ddrrw_pkg::ddrrw_cmd_t cmd,
  input wire logic [9:0]            col,
  input wire logic                  doing_rd,
  input wire logic                  wdata_valid,
  input wire logic                  rdata_valid
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence access_s;
    cmd == ddrrw_pkg::CMD_RD || cmd == ddrrw_pkg::CMD_WR;
  endsequence
  sequence open_row_s;
    cmd == ddrrw_pkg::CMD_ACT ##1 access_s;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  pch_then_act_a: assert property (cmd == ddrrw_pkg::CMD_PCH |=> open_row_s)
    else $error("precharge not followed by activate and access");
  act_then_cmd_a: assert property (cmd == ddrrw_pkg::CMD_ACT |=> access_s)
    else $error("activate not followed by access");
  rd_strobe_a: assert property (cmd == ddrrw_pkg::CMD_RD |-> doing_rd)
    else $error("read without read strobe");
  rd_start_a: assert property ($rose(doing_rd) |-> cmd == ddrrw_pkg::CMD_RD)
    else $error("read strobe without read command");
  rd_len_a: assert property (doing_rd ##1 doing_rd |=> !doing_rd)
    else $error("read strobe longer than two cycles");
  wr_valid_a: assert property (cmd == ddrrw_pkg::CMD_WR |-> wdata_valid)
    else $error("write without write valid");
  rw_apart_a: assert property (!(doing_rd && wdata_valid))
    else $error("read strobe and write valid together");
  col_shift_a: assert property (access_s |-> col[1:0] == 2'h0)
    else $error("memory column not shifted");
  rd_return_a: assert property (doing_rd |-> ##4 rdata_valid)
    else $error("read data not returned");
  rd_cause_a: assert property (rdata_valid |-> $past(doing_rd, 4))
    else $error("read valid without read");
endmodule : ddrrw_chk
`default_nettype wire

// ---- tb/tb.sv ----
/* Self-checking bench for controller and PHY ends joined by the link.
   Assumes 100 MHz clock; inputs driven at the falling edge. */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals and ends
  // ----------------------------------------
  logic sys_clk = 1'b0, resetn = 1'b0, half_rate = 1'b1, native_mode = 1'b1;
  logic read_req, write_req, size_error, ready, wdata_req, rdata_valid, pend;
  logic [1:0] ecc_lat, size;
  logic [23:0] addr;
  logic [31:0] wdata, rdata, mem_dq_i, seed = 32'h59D5;
  logic [3:0] be;
  logic [2:0] hist;
  logic [63:0] aq[$], rq[$], wq[$];
  int errors, num_checks, waits, e;
  always #5 sys_clk = ~sys_clk;
  ddrrw_phy_if link ();
  ddrrw_ctrl u_ddrrw_ctrl (.sys_clk(sys_clk), .resetn(resetn), .half_rate(half_rate), .native_mode(native_mode),
    .ecc_lat(ecc_lat), .read_req(read_req), .write_req(write_req), .size(size), .addr(addr), .ready(ready),
    .size_error(size_error), .wdata_req(wdata_req), .wdata(wdata), .user_byte_enables(be), .rdata(rdata),
    .rdata_valid(rdata_valid), .link(link.ctrl));
  ddrrw_phy u_ddrrw_phy (.sys_clk(sys_clk), .resetn(resetn), .link(link.phy), .mem_cmd(), .mem_row_addr(),
    .mem_col_addr(), .mem_bank_addr(), .mem_dq_o(), .mem_dq_i(mem_dq_i), .mem_dq_oe_n(), .memory_data_mask(),
    .mem_dqs_o(), .mem_dqs_oe_n());
  ddrrw_chk u_ddrrw_chk (.sys_clk(sys_clk), .resetn(resetn), .cmd(link.cmd), .col(link.col),
    .doing_rd(link.doing_rd), .wdata_valid(link.wdata_valid), .rdata_valid(link.rdata_valid));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // Held until taken; waits counts refused cycles
  task req(input logic wr, input logic [1:0] sz, input logic [23:0] a, input logic err);
    logic ok, se;
    read_req = !wr;
    write_req = wr;
    size = sz;
    addr = a;
    ok = 1'b0;
    while (ok !== 1'b1) begin
      #1;
      ok = ready;
      se = size_error;
      if (ok !== 1'b1) waits++;
      @(negedge sys_clk);
    end
    chk(se, err);
    if (!err) aq.push_back({a[23:22], a[21:8], a[7:0], 2'h0});
    if (!err && !wr) repeat (sz) rq.push_back(mem_dq_i);
  endtask : req
  // Settle wait lets the latency history empty
  task drain();
    read_req = 1'b0;
    write_req = 1'b0;
    for (int i = 0; i < 300 && aq.size() + rq.size() + wq.size() > 0; i++) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
  endtask : drain
  // ----------------------------------------
  // Responder and monitor
  // ----------------------------------------
  always @(posedge sys_clk) begin
    hist <= {hist[1:0], link.rdata_valid};
    pend <= wdata_req === 1'b1;
  end
  always @(negedge sys_clk) begin
    if (pend) begin
      seed = rnd(seed);
      wdata = seed;
      be = seed[7:4];
      wq.push_back({wdata, ~be});
    end
    if (link.cmd inside {ddrrw_pkg::CMD_RD, ddrrw_pkg::CMD_WR}) chk({link.bank, link.row, link.col}, aq.pop_front());
    if (link.wdata_valid === 1'b1) chk({link.wdata, link.wdata_mask}, wq.pop_front());
    if (rdata_valid === 1'b1) chk(rdata, rq.pop_front());
    chk(rdata_valid, e == 0 ? link.rdata_valid : hist[e-1]);
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {read_req, write_req, size, addr, ecc_lat, wdata, be, hist, pend} = '0;
    mem_dq_i = seed;
    repeat (12) @(negedge sys_clk);
    resetn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = rnd(seed);
      req(1'b0, 2'h1, i == 0 ? 24'h000004 : i == 1 ? 24'h000804 : seed[23:0], 1'b0);
      if (i == 3) chk(waits, 0);
    end
    chk(waits > 0, 1);
    req(1'b0, 2'h2, 24'h000010, 1'b1);
    req(1'b1, 2'h1, 24'h000008, 1'b0);
    req(1'b1, 2'h1, 24'h00000A, 1'b0);
    drain();
    for (int k = 3; k >= 0; k--) begin
      ecc_lat = k[1:0];
      e = k == 2 ? 0 : k;
      mem_dq_i = rnd(mem_dq_i);
      req(1'b0, 2'h1, 24'h000004, 1'b0);
      drain();
    end
    half_rate = 1'b0;
    for (int i = 0; i < 5; i++) begin
      seed = rnd(seed);
      req(i[0], i == 4 ? 2'h3 : i[1] ? 2'h2 : 2'h1, seed[23:0], i == 4);
    end
    drain();
    // Memory-mapped writes: first word rides with the request into the buffer
    native_mode = 1'b0;
    for (int n = 0; n < 8; n++) begin
      seed = rnd(seed);
      wdata = seed;
      be = seed[7:4];
      wq.push_back({seed, ~seed[7:4]});
      req(1'b1, 2'h1, {16'h0, n[7:0]}, 1'b0);
      chk(wdata_req, 0);
    end
    drain();
    chk(wq.size(), 0);
    chk(ready, 1);
    chk(aq.size() + rq.size() + wq.size(), 0);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
